// *** rtl/sbst_map.vh ***
`ifndef SBST_MAP_VH
`define SBST_MAP_VH
// scan register widths
`define SBST_IR_W 4
`define SBST_ID_W 32
// boundary cells: functional inputs, outputs, one output-enable cell
`define SBST_NIN 8
`define SBST_NOUT 4
`define SBST_CHAIN_W 13
`define SBST_CELL_OUT_LO 8
`define SBST_CELL_OE 12
// opcodes
`define SBST_OP_PIN_DRIVE 4'h0
`define SBST_OP_PIN_CAPTURE 4'h1
`define SBST_OP_ID_LOAD 4'h2
`define SBST_OP_FLOAT 4'h3
`define SBST_OP_CLAMP 4'h8
`define SBST_OP_CAPTURE_PAT 4'hd
`define SBST_OP_BYPASS 4'hf
// instruction selected after test reset
`define SBST_IR_RESET 4'h2
// identification fields, values arbitrary
`define SBST_ID_REV 4'h1
`define SBST_ID_DEV 16'h0abc
`define SBST_ID_VENDOR 11'h155
`define SBST_ID_MARK 1'h1
`endif

// *** rtl/sbst_cell_chain.v ***
`timescale 1ns/100ps
`include "sbst_map.vh"
module sbst_cell_chain
(
  input wire mclk,
  input wire nrst,
  input wire capture,
  input wire shift,
  input wire update,
  input wire sdi,
  input wire [`SBST_CHAIN_W-1:0] parIn,
  output wire sout,
  output wire [`SBST_CHAIN_W-1:0] updOut
);
  wire [`SBST_CHAIN_W:0] serIn;
  wire [`SBST_CHAIN_W-1:0] updQ;

  assign serIn[`SBST_CHAIN_W] = sdi;
  assign sout = serIn[0];
  assign updOut = updQ;

  genvar i;
  generate
    for (i = 0; i < `SBST_CHAIN_W; i = i + 1)
    begin : gCell
      reg shift_ff;
      reg upd_ff;
      assign serIn[i] = shift_ff;
      assign updQ[i] = upd_ff;
      always @(posedge mclk)
      begin
        if (!nrst)
        begin
          shift_ff <= 1'b0;
          upd_ff <= 1'b0;
        end
        else
        begin
          if (capture)
            shift_ff <= parIn[i];
          else if (shift)
            shift_ff <= serIn[i+1];
          if (update)
            upd_ff <= shift_ff;
        end
      end
    end
  endgenerate
endmodule

// *** rtl/sbst_tap.v ***
// Notes on behaviour
// R1: a 4-bit instruction, 1-bit bypass and 32-bit id register sit between tdi and tdo.
// R2: the id register holds revision in 31:28, device in 27:12, vendor in 11:1.
// R3: bit 0 of the id register is always one.
// R4: opcode 0000 drives cell contents onto the outputs and selects the cell chain.
// R5: opcode 0001 selects the cell chain, capturing pins and allowing preload.
// R6: opcode 0010 loads the id value and selects the id register.
// R7: opcode 0011 floats all functional outputs and selects the bypass bit.
// R8: opcode 1000 drives cell contents onto the outputs and selects the bypass bit.
// R9: passing Capture-IR loads the pattern 1101 into the instruction register.
// R10: opcode 1111 selects the single bypass bit.
// R11: the tester loads only the six defined opcodes; the testbench also loads the reserved codes 4, 9 and e.
// R12: test logic resets at power-up, and the optional trstN may also reset it.
// R13: cells cover all functional inputs and outputs besides the test pins.
// R14: the sixteen-state machine steps on tck rise by tms; tdo changes on tck fall.
// R15: a reserved opcode acts as bypass with outputs under normal control.
`timescale 1ns/100ps
`include "sbst_map.vh"
module sbst_tap
(
  input wire mclk,
  input wire nrst,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trstN,
  output reg tdo,
  output reg tdoEn,
  input wire [`SBST_NIN-1:0] pinIn,
  output reg [`SBST_NIN-1:0] coreIn,
  input wire [`SBST_NOUT-1:0] coreOut,
  input wire coreOe,
  output reg [`SBST_NOUT-1:0] pinOut,
  output reg pinOe
);
  localparam [15:0] ST_TLR = 16'h0001;
  localparam [15:0] ST_RTI = 16'h0002;
  localparam [15:0] ST_SEL_DR = 16'h0004;
  localparam [15:0] ST_CAP_DR = 16'h0008;
  localparam [15:0] ST_SH_DR = 16'h0010;
  localparam [15:0] ST_EX1_DR = 16'h0020;
  localparam [15:0] ST_PAU_DR = 16'h0040;
  localparam [15:0] ST_EX2_DR = 16'h0080;
  localparam [15:0] ST_UPD_DR = 16'h0100;
  localparam [15:0] ST_SEL_IR = 16'h0200;
  localparam [15:0] ST_CAP_IR = 16'h0400;
  localparam [15:0] ST_SH_IR = 16'h0800;
  localparam [15:0] ST_EX1_IR = 16'h1000;
  localparam [15:0] ST_PAU_IR = 16'h2000;
  localparam [15:0] ST_EX2_IR = 16'h4000;
  localparam [15:0] ST_UPD_IR = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and tck edge detect
  reg tckS1_ff, tckS2_ff, tckD_ff;
  reg tmsS1_ff, tmsS2_ff;
  reg tdiS1_ff, tdiS2_ff;
  reg trstS1_ff, trstS2_ff;
  reg [`SBST_NIN-1:0] pinInS1_ff;
  wire tckRise;
  wire tckFall;
  wire tapRst;

  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      tckS1_ff <= 1'b0;
      tckS2_ff <= 1'b0;
      tckD_ff <= 1'b0;
      tmsS1_ff <= 1'b1;
      tmsS2_ff <= 1'b1;
      tdiS1_ff <= 1'b1;
      tdiS2_ff <= 1'b1;
      trstS1_ff <= 1'b1;
      trstS2_ff <= 1'b1;
      pinInS1_ff <= {`SBST_NIN{1'b0}};
      coreIn <= {`SBST_NIN{1'b0}};
    end
    else
    begin
      tckS1_ff <= tck;
      tckS2_ff <= tckS1_ff;
      tckD_ff <= tckS2_ff;
      tmsS1_ff <= tms;
      tmsS2_ff <= tmsS1_ff;
      tdiS1_ff <= tdi;
      tdiS2_ff <= tdiS1_ff;
      trstS1_ff <= trstN;
      trstS2_ff <= trstS1_ff;
      pinInS1_ff <= pinIn;
      coreIn <= pinInS1_ff;
    end
  end

  assign tckRise = tckS2_ff & ~tckD_ff;
  assign tckFall = ~tckS2_ff & tckD_ff;
  // power-up reset comes in on nrst
  assign tapRst = !nrst || !trstS2_ff; // R12

  ////////////////////////////////////////////////////////////////////////////
  // test state machine
  reg [15:0] state_ff;
  reg [15:0] nxt_state;

  always @*
  begin
    case (state_ff) // R14
      ST_TLR: nxt_state = tmsS2_ff ? ST_TLR : ST_RTI;
      ST_RTI: nxt_state = tmsS2_ff ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: nxt_state = tmsS2_ff ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = tmsS2_ff ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: nxt_state = tmsS2_ff ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_state = tmsS2_ff ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_state = tmsS2_ff ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_state = tmsS2_ff ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = tmsS2_ff ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: nxt_state = tmsS2_ff ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: nxt_state = tmsS2_ff ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: nxt_state = tmsS2_ff ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_state = tmsS2_ff ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_state = tmsS2_ff ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_state = tmsS2_ff ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = tmsS2_ff ? ST_SEL_DR : ST_RTI;
      default: nxt_state = ST_TLR;
    endcase
  end

  always @(posedge mclk)
  begin
    if (tapRst)
      state_ff <= ST_TLR; // R12
    else if (tckRise)
      state_ff <= nxt_state; // R14
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction register and decode
  reg [`SBST_IR_W-1:0] irShift_ff;
  reg [`SBST_IR_W-1:0] instr_ff;
  wire selId;
  wire selChain;
  wire driveCells;
  wire floatOut;

  always @(posedge mclk)
  begin
    if (tapRst)
    begin
      irShift_ff <= `SBST_OP_CAPTURE_PAT;
      instr_ff <= `SBST_IR_RESET;
    end
    else if (state_ff == ST_TLR)
      instr_ff <= `SBST_IR_RESET;
    else if (tckRise)
    begin
      if (state_ff == ST_CAP_IR)
        irShift_ff <= `SBST_OP_CAPTURE_PAT; // R9
      else if (state_ff == ST_SH_IR)
        irShift_ff <= {tdiS2_ff, irShift_ff[`SBST_IR_W-1:1]}; // R1
      else if (state_ff == ST_UPD_IR)
        instr_ff <= irShift_ff;
    end
  end

  assign selId = instr_ff == `SBST_OP_ID_LOAD; // R6
  assign selChain = instr_ff == `SBST_OP_PIN_DRIVE ||
                    instr_ff == `SBST_OP_PIN_CAPTURE; // R4 R5
  // every other code, reserved ones included, selects bypass
  assign driveCells = instr_ff == `SBST_OP_PIN_DRIVE ||
                      instr_ff == `SBST_OP_CLAMP; // R4 R8
  assign floatOut = instr_ff == `SBST_OP_FLOAT; // R7

  ////////////////////////////////////////////////////////////////////////////
  // data registers
  reg bypass_ff;
  reg [`SBST_ID_W-1:0] idShift_ff;
  wire capDr;
  wire shDr;
  wire updDr;
  wire chainOut;
  wire [`SBST_CHAIN_W-1:0] cellUpd;
  wire [`SBST_ID_W-1:0] idValue;

  assign capDr = tckRise && state_ff == ST_CAP_DR;
  assign shDr = tckRise && state_ff == ST_SH_DR;
  assign updDr = tckRise && state_ff == ST_UPD_DR;
  assign idValue = {`SBST_ID_REV, `SBST_ID_DEV, `SBST_ID_VENDOR,
                    `SBST_ID_MARK}; // R2 R3

  always @(posedge mclk)
  begin
    if (tapRst)
    begin
      bypass_ff <= 1'b0;
      idShift_ff <= {`SBST_ID_W{1'b0}};
    end
    else
    begin
      if (capDr && !selId && !selChain)
        bypass_ff <= 1'b0; // R10 R15
      else if (shDr && !selId && !selChain)
        bypass_ff <= tdiS2_ff; // R7 R8 R10 R15
      if (capDr && selId)
        idShift_ff <= idValue; // R6
      else if (shDr && selId)
        idShift_ff <= {tdiS2_ff, idShift_ff[`SBST_ID_W-1:1]}; // R1
    end
  end

  sbst_cell_chain uChain
  (
    .mclk(mclk),
    .nrst(!tapRst),
    .capture(capDr && selChain), // R5
    .shift(shDr && selChain), // R4 R5
    .update(updDr && selChain),
    .sdi(tdiS2_ff),
    .parIn({pinOe, pinOut, coreIn}), // R13
    .sout(chainOut),
    .updOut(cellUpd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial output, changes on tck fall
  always @(posedge mclk)
  begin
    if (tapRst)
    begin
      tdo <= 1'b0;
      tdoEn <= 1'b0;
    end
    else if (tckFall)
    begin
      if (state_ff == ST_SH_IR)
      begin
        tdo <= irShift_ff[0]; // R14
        tdoEn <= 1'b1;
      end
      else if (state_ff == ST_SH_DR)
      begin
        tdo <= selId ? idShift_ff[0] : (selChain ? chainOut : bypass_ff);
        tdoEn <= 1'b1;
      end
      else
        tdoEn <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // functional output mux
  always @(posedge mclk)
  begin
    if (!nrst)
    begin
      pinOut <= {`SBST_NOUT{1'b0}};
      pinOe <= 1'b0;
    end
    else
    begin
      pinOut <= driveCells ?
        cellUpd[`SBST_CELL_OUT_LO +: `SBST_NOUT] : coreOut; // R4 R8
      if (floatOut)
        pinOe <= 1'b0; // R7
      else if (driveCells)
        pinOe <= cellUpd[`SBST_CELL_OE]; // R4 R8
      else
        pinOe <= coreOe; // R15
    end
  end
endmodule

// *** tb/sbst_tap_monitor.sv ***
`timescale 1ns/100ps
`include "sbst_map.vh"
module sbst_tap_monitor
(
  input wire mclk,
  input wire nrst,
  input wire tck,
  input wire trstN,
  input wire tdo,
  input wire tdoEn,
  input wire [`SBST_NIN-1:0] pinIn,
  input wire [`SBST_NIN-1:0] coreIn,
  input wire [`SBST_NOUT-1:0] coreOut,
  input wire coreOe,
  input wire [`SBST_NOUT-1:0] pinOut,
  input wire pinOe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // nothing that could move the pin mux
  sequence quietIn;
    $stable(coreOut) && $stable(coreOe) && $stable(tck) && $stable(trstN);
  endsequence
  a_reset_clears:
    assert property (disable iff (1'b0) !nrst |=> !tdo && !tdoEn && !pinOe
      && !pinOut && !coreIn) else $error("reset");
  a_core_sync:
    assert property (nrst [*3] |-> coreIn == $past(pinIn, 2)) else $error("in");
  a_tdo_on_fall:
    assert property ($changed(tdo) |-> !$past(tck, 2)) else $error("tdo");
  a_tdoen_on_fall:
    assert property ($changed(tdoEn) |-> !$past(tck, 2)) else $error("en");
  a_trst_clears:
    assert property (!trstN [*4] |-> !tdo && !tdoEn) else $error("trst");
  a_pins_quiet:
    assert property (quietIn [*6] |=> $stable(pinOut) && $stable(pinOe))
      else $error("pins");
  a_idle_after_reset:
    assert property ($rose(nrst) |-> !tdoEn [*8]) else $error("nrst");
  a_idle_after_trst:
    assert property ($rose(trstN) |-> !tdoEn [*8]) else $error("trstN");
endmodule

// *** tb/sbst_jtag_master.sv ***
`timescale 1ns/100ps
module sbst_jtag_master
(
  input wire mclk,
  input wire tdo,
  output reg tck = 1'b0,
  output reg tms = 1'b1,
  output reg tdi = 1'b0
);
  reg o;
  integer i;
  // tck stands low between calls; tdo read late in the high half
  task step(input m, input d);
    begin
      tms = m;
      tdi = d;
      repeat (4) @(negedge mclk);
      tck = 1'b1;
      repeat (4) @(negedge mclk);
      o = tdo;
      tck = 1'b0;
    end
  endtask
  task tlr;
    begin
      repeat (5) step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
  endtask
  task scan(input ir, input integer n, input [31:0] din,
    output [31:0] dout);
    begin
      dout = 32'h0;
      step(1'b1, 1'b0);
      if (ir)
        step(1'b1, 1'b0);
      repeat (2) step(1'b0, 1'b0);
      for (i = 0; i < n; i = i + 1)
      begin
        step(i == n - 1, din[i]);
        dout[i] = o;
      end
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
`include "sbst_map.vh"
module tb;
  // defined codes, one row per nibble, lowest first
  localparam [23:0] OPS = 24'hf32081;
  // reserved codes
  localparam [11:0] RSV = 12'he94;
  localparam [31:0] DIN = 32'hda3c1a5c;
  localparam [31:0] ID = {`SBST_ID_REV, `SBST_ID_DEV, `SBST_ID_VENDOR,
    1'b1};
  reg mclk = 1'b0;
  reg nrst, trstN, coreOe;
  reg [7:0] pinIn;
  reg [3:0] coreOut;
  reg [12:0] cells;
  reg [31:0] dout, expV;
  wire tck, tms, tdi, tdo, tdoEn, pinOe;
  wire [7:0] coreIn;
  wire [3:0] pinOut;
  integer numErrors, checksDone, r;
  sbst_tap sbst_tap_inst (.mclk(mclk), .nrst(nrst), .tck(tck), .tms(tms),
    .tdi(tdi), .trstN(trstN), .tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn),
    .coreIn(coreIn), .coreOut(coreOut), .coreOe(coreOe), .pinOut(pinOut),
    .pinOe(pinOe));
  sbst_jtag_master sbst_jtag_master_inst (.mclk(mclk), .tdo(tdo),
    .tck(tck), .tms(tms), .tdi(tdi));
  task check(input [31:0] seen, input [31:0] want);
    begin
      checksDone = checksDone + 1;
      if (seen !== want)
      begin
        numErrors = numErrors + 1;
        $display("BAD %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task stopTest;
    begin
      $display("errors %0d checks %0d", numErrors, checksDone);
      if (numErrors == 0 && checksDone > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  function [4:0] pins(input [3:0] c);
    pins = (c == 4'h0 || c == 4'h8) ? cells[12:8] :
      {c != 4'h3 && coreOe, coreOut};
  endfunction
  task ir(input [3:0] c);
    begin
      sbst_jtag_master_inst.scan(1'b1, 4, {28'h0, c}, dout);
      check(dout[3:0], 4'hd);
    end
  endtask
  task dr;
    sbst_jtag_master_inst.scan(1'b0, 32, DIN, dout);
  endtask
  // one row: load code, scan a data word, look at pins
  task runRow(input [3:0] c);
    begin
      pinIn = {c, ~c};
      coreOut = ~c;
      coreOe = ~c[2];
      ir(c);
      dr;
      if (c == 4'h2)
        expV = ID;
      else if (c <= 4'h1)
        expV = {DIN[18:0], pins(c), pinIn};
      else
        expV = {DIN[30:0], 1'b0};
      check(dout, expV);
      // last 13 bits shifted in sit in the cells
      if (c <= 4'h1)
        cells = DIN[31:19];
      check({pinOe, pinOut}, pins(c));
    end
  endtask
  initial
    forever #50 mclk = ~mclk;
  initial
  begin
    repeat (60000) @(posedge mclk);
    numErrors = numErrors + 1;
    stopTest;
  end
  initial
  begin
    numErrors = 0;
    checksDone = 0;
    nrst = 1'b0;
    trstN = 1'b1;
    coreOe = 1'b1;
    coreOut = 4'h6;
    pinIn = 8'hc3;
    cells = 13'h0;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    sbst_jtag_master_inst.tlr;
    dr;
    check(dout, ID);
    for (r = 0; r < 6; r = r + 1)
      runRow(OPS[4 * r +: 4]);
    // reserved codes probed on purpose
    for (r = 0; r < 3; r = r + 1)
      runRow(RSV[4 * r +: 4]);
    sbst_jtag_master_inst.tlr;
    dr;
    check(dout, ID);
    coreOe = 1'b1;
    ir(4'h3);
    check(pinOe, 1'b0);
    trstN = 1'b0;
    repeat (5) @(negedge mclk);
    trstN = 1'b1;
    repeat (3) @(negedge mclk);
    check(pinOe, coreOe);
    // test reset leaves the state machine in Test-Logic-Reset
    sbst_jtag_master_inst.tlr;
    ir(4'h0);
    nrst = 1'b0;
    repeat (3) @(negedge mclk);
    check({tdo, tdoEn, pinOe, pinOut, coreIn}, 15'h0);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    sbst_jtag_master_inst.tlr;
    dr;
    check(dout, ID);
    stopTest;
  end
endmodule
bind sbst_tap sbst_tap_monitor sbst_tap_monitor_inst (.mclk(mclk),
  .nrst(nrst), .tck(tck), .trstN(trstN), .tdo(tdo), .tdoEn(tdoEn),
  .pinIn(pinIn), .coreIn(coreIn), .coreOut(coreOut), .coreOe(coreOe),
  .pinOut(pinOut), .pinOe(pinOe));
